// File: hw/serial_port_pkg.sv
/*
 Constants, register map and carrier types for the buffered serial port
 data paths. Assumes a 125 MHz ref_clk and an AXI4-Lite master.
*/
// Operation
// - Bits go shift stage, buffer, receive register.
// - Unread receive register stalls buffer drain; only a full buffer stalls the shift-stage copy.
// - Stall sets receive-full; shift stage gets overwritten.
// - Receive-full raises no interrupt; poll it.
// - Early receive sync aborts, restarts reception.
// - Early receive sync drops word, sets error.
// - Early transmit sync aborts, restarts transmission.
// - Early transmit sync loses word, sets error.
// - Written transmit word copied into shift stage.
// - Transmit sync shifts stage out on pin.
// - No new word: resend previous on sync.
// - Transmit-empty reads 0 while repeating stale data.
// - Transmit-empty raises no interrupt; poll it.
package serial_port_pkg;
	localparam int WORD_BITS = 16;
	localparam logic [4:0] WORD_LAST = 5'h0f;
	// Register byte offsets
	localparam logic [7:0] OFS_RX_DATA = 8'h00;
	localparam logic [7:0] OFS_TX_DATA = 8'h04;
	localparam logic [7:0] OFS_STATUS = 8'h08;
	localparam logic [7:0] OFS_IRQ_STAT = 8'h0c;
	localparam logic [7:0] OFS_IRQ_MASK = 8'h10;
	// Status field positions
	localparam int ST_RXFULL = 0;
	localparam int ST_TXEMPTY = 1;
	localparam int ST_RXSYNCERR = 2;
	localparam int ST_TXSYNCERR = 3;
	// Interrupt bit positions
	localparam int IRQ_RXSYNC = 0;
	localparam int IRQ_TXSYNC = 1;
	localparam logic [1:0] IRQ_MASK_RESET = 2'h0;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// Sampled link inputs after synchronising
	typedef struct packed {
		logic clk;
		logic rxSync;
		logic rxData;
		logic txSync;
	} link_in_t;
endpackage

// File: hw/buffered_serial_port.sv
/*
 Receive and transmit data paths of a buffered serial port with overrun,
 frame-sync and underflow detection, AXI4-Lite register slave.
 Assumes the link clock, syncs and data come from another domain; frame
 syncs are sampled on rising link clock edges, data driven on falling.
*/
module buffered_serial_port
	import serial_port_pkg::*;
(
	input wire logic ref_clk,
	input wire logic reset_n,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic linkClk,
	input wire logic rxFrameSync,
	input wire logic rxDataPin,
	input wire logic txFrameSync,
	output logic txDataPin,
	output logic irq
);
	// Three-stage synchronisers; only stages 2 and 3 are looked at
	link_in_t s1Reg, s2Reg, s3Reg;
	link_in_t rawIn;
	logic linkLvl_reg, linkLvl_next;
	assign rawIn = '{clk: linkClk, rxSync: rxFrameSync,
		rxData: rxDataPin, txSync: txFrameSync};
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			s1Reg <= '0;
			s2Reg <= '0;
			s3Reg <= '0;
			linkLvl_reg <= 1'b0;
		end else begin
			s1Reg <= rawIn;
			s2Reg <= s1Reg;
			s3Reg <= s2Reg;
			linkLvl_reg <= linkLvl_next;
		end
	end
	// Level moves once stages 2 and 3 agree; a lone glitch is ignored
	logic linkRise, linkFall;
	assign linkLvl_next = (s2Reg.clk == s3Reg.clk) ? s3Reg.clk
		: linkLvl_reg;
	assign linkRise = linkLvl_next & ~linkLvl_reg;
	assign linkFall = ~linkLvl_next & linkLvl_reg;
	// Bus side signals
	logic wrFire, rdFire, rxRead, txWrite;
	logic [31:0] wrData;
	// Receive path state
	logic [WORD_BITS-1:0] rxShift_reg, rxShift_next;
	logic [4:0] rxCnt_reg, rxCnt_next;
	logic rxActive_reg, rxActive_next;
	logic [WORD_BITS-1:0] rxBuf_reg, rxBuf_next;
	logic rxBufValid_reg, rxBufValid_next;
	logic [WORD_BITS-1:0] rxData_reg, rxData_next;
	logic rxFull_reg, rxFull_next;
	logic rxUnread_reg, rxUnread_next;
	logic rxSyncErrEv;
	// Receive stages; a sync mid-word restarts the word
	always_comb begin
		logic wordDone;
		wordDone = 1'b0;
		rxShift_next = rxShift_reg;
		rxCnt_next = rxCnt_reg;
		rxActive_next = rxActive_reg;
		rxBuf_next = rxBuf_reg;
		rxBufValid_next = rxBufValid_reg;
		rxData_next = rxData_reg;
		rxUnread_next = rxUnread_reg;
		rxFull_next = rxFull_reg;
		rxSyncErrEv = 1'b0;
		if (linkRise) begin
			if (s3Reg.rxSync) begin
				rxSyncErrEv = rxActive_reg;
				rxActive_next = 1'b1;
				rxCnt_next = 5'h01;
				rxShift_next = {{(WORD_BITS-1){1'b0}}, s3Reg.rxData};
			end else if (rxActive_reg) begin
				rxShift_next = {rxShift_reg[WORD_BITS-2:0], s3Reg.rxData};
				rxCnt_next = rxCnt_reg + 5'h01;
				if (rxCnt_reg == WORD_LAST) begin
					wordDone = 1'b1;
					rxActive_next = 1'b0;
				end
			end
		end
		if (rxRead) begin
			rxUnread_next = 1'b0;
			rxFull_next = 1'b0;
		end
		// Drain buffer into the receive register when it is free
		if (rxBufValid_reg && !rxUnread_next) begin
			rxData_next = rxBuf_reg;
			rxUnread_next = 1'b1;
			rxBufValid_next = 1'b0;
		end
		if (wordDone) begin
			if (!rxBufValid_next) begin
				rxBuf_next = rxShift_next;
				rxBufValid_next = 1'b1;
			end else begin
				rxFull_next = 1'b1;
			end
		end
	end
	// Receive state registers
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			rxShift_reg <= '0;
			rxCnt_reg <= '0;
			rxActive_reg <= 1'b0;
			rxBuf_reg <= '0;
			rxBufValid_reg <= 1'b0;
			rxData_reg <= '0;
			rxUnread_reg <= 1'b0;
			rxFull_reg <= 1'b0;
		end else begin
			rxShift_reg <= rxShift_next;
			rxCnt_reg <= rxCnt_next;
			rxActive_reg <= rxActive_next;
			rxBuf_reg <= rxBuf_next;
			rxBufValid_reg <= rxBufValid_next;
			rxData_reg <= rxData_next;
			rxUnread_reg <= rxUnread_next;
			rxFull_reg <= rxFull_next;
		end
	end
	// Transmit path state
	logic [WORD_BITS-1:0] txHold_reg, txHold_next;
	logic txNew_reg, txNew_next;
	logic [WORD_BITS-1:0] txShift_reg, txShift_next;
	logic [4:0] txCnt_reg, txCnt_next;
	logic txActive_reg, txActive_next;
	logic txPend_reg, txPend_next;
	logic txEmpty_reg, txEmpty_next;
	logic txPin_reg, txPin_next;
	logic txSyncErrEv;
	// Transmit: sync latches a word, falling edges drive bits
	always_comb begin
		txHold_next = txHold_reg;
		txNew_next = txNew_reg;
		txShift_next = txShift_reg;
		txCnt_next = txCnt_reg;
		txActive_next = txActive_reg;
		txPend_next = txPend_reg;
		txEmpty_next = txEmpty_reg;
		txPin_next = txPin_reg;
		txSyncErrEv = 1'b0;
		if (txWrite) begin
			txHold_next = wrData[WORD_BITS-1:0];
			txNew_next = 1'b1;
		end
		if (linkRise && s3Reg.txSync) begin
			txSyncErrEv = txActive_reg | txPend_reg;
			txShift_next = txHold_reg;
			txEmpty_next = txNew_reg;
			txNew_next = txWrite;
			txPend_next = 1'b1;
			txActive_next = 1'b0;
		end else if (linkFall && (txPend_reg || txActive_reg)) begin
			txPin_next = txShift_reg[WORD_BITS-1];
			txShift_next = {txShift_reg[WORD_BITS-2:0], 1'b0};
			txCnt_next = txPend_reg ? 5'h01 : txCnt_reg + 5'h01;
			txPend_next = 1'b0;
			txActive_next = !(!txPend_reg && txCnt_reg == WORD_LAST);
		end
	end
	// Transmit state registers
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			txHold_reg <= '0;
			txNew_reg <= 1'b0;
			txShift_reg <= '0;
			txCnt_reg <= '0;
			txActive_reg <= 1'b0;
			txPend_reg <= 1'b0;
			txEmpty_reg <= 1'b1;
			txPin_reg <= 1'b0;
		end else begin
			txHold_reg <= txHold_next;
			txNew_reg <= txNew_next;
			txShift_reg <= txShift_next;
			txCnt_reg <= txCnt_next;
			txActive_reg <= txActive_next;
			txPend_reg <= txPend_next;
			txEmpty_reg <= txEmpty_next;
			txPin_reg <= txPin_next;
		end
	end
	assign txDataPin = txPin_reg;
	// Sticky sync error flags; only these two can interrupt
	logic [1:0] irqStat_reg, irqStat_next;
	logic [1:0] irqMask_reg, irqMask_next;
	logic [1:0] w1c;
	always_comb begin
		w1c = (wrFire && s_axi_awaddr == OFS_IRQ_STAT) ? wrData[1:0] : 2'h0;
		irqStat_next = irqStat_reg & ~w1c;
		// Set after clear so a same-cycle event is kept
		if (rxSyncErrEv)
			irqStat_next[IRQ_RXSYNC] = 1'b1;
		if (txSyncErrEv)
			irqStat_next[IRQ_TXSYNC] = 1'b1;
		irqMask_next = irqMask_reg;
		if (wrFire && s_axi_awaddr == OFS_IRQ_MASK)
			irqMask_next = wrData[1:0];
	end
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			irqStat_reg <= '0;
			irqMask_reg <= IRQ_MASK_RESET;
		end else begin
			irqStat_reg <= irqStat_next;
			irqMask_reg <= irqMask_next;
		end
	end
	// Full and empty flags stay out of the interrupt
	assign irq = |(irqStat_reg & irqMask_reg);
	// AXI4-Lite slave: takes address and data together, one at a time
	logic bValid_reg, bValid_next, rValid_reg, rValid_next;
	logic [1:0] bResp_reg, bResp_next, rResp_reg, rResp_next;
	logic [31:0] rData_reg, rData_next;
	logic wrOk;
	assign wrFire = s_axi_awvalid & s_axi_wvalid & ~bValid_reg;
	assign rdFire = s_axi_arvalid & ~rValid_reg;
	assign s_axi_awready = wrFire;
	assign s_axi_wready = wrFire;
	assign s_axi_arready = rdFire;
	assign wrData = s_axi_wdata;
	assign wrOk = s_axi_awaddr == OFS_TX_DATA ||
		s_axi_awaddr == OFS_IRQ_STAT || s_axi_awaddr == OFS_IRQ_MASK;
	assign txWrite = wrFire && s_axi_awaddr == OFS_TX_DATA;
	assign rxRead = rdFire && s_axi_araddr == OFS_RX_DATA;
	always_comb begin
		logic [31:0] st;
		st = 32'h0;
		st[ST_RXFULL] = rxFull_reg;
		st[ST_TXEMPTY] = txEmpty_reg;
		st[ST_RXSYNCERR] = irqStat_reg[IRQ_RXSYNC];
		st[ST_TXSYNCERR] = irqStat_reg[IRQ_TXSYNC];
		bValid_next = bValid_reg & ~s_axi_bready;
		bResp_next = bResp_reg;
		if (wrFire) begin
			bValid_next = 1'b1;
			bResp_next = wrOk ? RESP_OKAY : RESP_SLVERR;
		end
		rValid_next = rValid_reg & ~s_axi_rready;
		rResp_next = rResp_reg;
		rData_next = rData_reg;
		if (rdFire) begin
			rValid_next = 1'b1;
			rResp_next = RESP_OKAY;
			case (s_axi_araddr)
				OFS_RX_DATA: rData_next = {16'h0000, rxData_reg};
				OFS_TX_DATA: rData_next = {16'h0000, txHold_reg};
				OFS_STATUS: rData_next = st;
				OFS_IRQ_STAT: rData_next = {30'h0, irqStat_reg};
				OFS_IRQ_MASK: rData_next = {30'h0, irqMask_reg};
				default: begin
					rData_next = 32'h0;
					rResp_next = RESP_SLVERR;
				end
			endcase
		end
	end
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			bValid_reg <= 1'b0;
			bResp_reg <= RESP_OKAY;
			rValid_reg <= 1'b0;
			rResp_reg <= RESP_OKAY;
			rData_reg <= '0;
		end else begin
			bValid_reg <= bValid_next;
			bResp_reg <= bResp_next;
			rValid_reg <= rValid_next;
			rResp_reg <= rResp_next;
			rData_reg <= rData_next;
		end
	end
	assign s_axi_bvalid = bValid_reg;
	assign s_axi_bresp = bResp_reg;
	assign s_axi_rvalid = rValid_reg;
	assign s_axi_rresp = rResp_reg;
	assign s_axi_rdata = rData_reg;
	// Checks on the data paths
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!reset_n);
	chk_rx_stall_hold: assert property (
		rxUnread_reg && !rxRead |=> $stable(rxData_reg))
		else $error("receive register changed while unread");
	chk_rx_full_set: assert property (
		!rxFull_reg && rxBufValid_reg && rxUnread_reg && !rxRead
		&& linkRise && !s3Reg.rxSync && rxActive_reg
		&& rxCnt_reg == WORD_LAST |=> rxFull_reg)
		else $error("overrun did not set receive-full");
	chk_rx_full_clear: assert property (
		rxRead |=> !rxFull_reg)
		else $error("read did not clear receive-full");
	chk_rx_sync_err: assert property (
		linkRise && s3Reg.rxSync && rxActive_reg
		|=> irqStat_reg[IRQ_RXSYNC] && rxCnt_reg == 5'h01)
		else $error("early receive sync not flagged");
	chk_tx_sync_err: assert property (
		linkRise && s3Reg.txSync && txActive_reg
		|=> irqStat_reg[IRQ_TXSYNC] && txPend_reg)
		else $error("early transmit sync not flagged");
	chk_tx_repeat: assert property (
		linkRise && s3Reg.txSync |=> txShift_reg == $past(txHold_reg))
		else $error("shift stage not loaded on sync");
	chk_tx_empty: assert property (
		linkRise && s3Reg.txSync && !txNew_reg |=> !txEmpty_reg)
		else $error("underflow not shown on transmit-empty");
	chk_irq_quiet: assert property (
		irqStat_reg == 2'h0 |-> !irq)
		else $error("interrupt without sync error");
	chk_tx_bit: assert property (
		linkFall && txPend_reg && !(linkRise && s3Reg.txSync)
		|=> txDataPin == $past(txShift_reg[WORD_BITS-1]))
		else $error("first bit not driven");
	cov_overrun: cover property (rxFull_reg);
	cov_rx_err: cover property (rxSyncErrEv);
	cov_tx_err: cover property (txSyncErrEv);
	cov_underflow: cover property (!txEmpty_reg);
endmodule

// File: verification/serial_link_model.sv
/*
 Far-side serial device model: makes the link clock, both frame syncs and
 receive data, and captures transmit data. Assumes the port samples syncs
 and data on link clock rises and drives transmit bits on falls.
*/
module serial_link_model (
	output logic linkClk,
	output logic rxFrameSync,
	output logic rxDataPin,
	output logic txFrameSync,
	input wire logic txDataPin
);
	timeunit 1ns;
	timeprecision 1ps;

	// Link idles low with its clock stopped
	initial begin
		linkClk = 1'b0;
		rxFrameSync = 1'b0;
		rxDataPin = 1'b0;
		txFrameSync = 1'b0;
	end

	// One frame of bits, 160 ns clock; a short count makes an early sync
	task automatic frame(input logic [15:0] rxWord, input int bits,
		input logic rxOn, input logic txOn, output logic [15:0] txSeen);
		txSeen = 16'h0000;
		for (int i = 0; i <= bits; i++) begin
			rxFrameSync <= rxOn && (i == 0);
			txFrameSync <= txOn && (i == 0);
			// Past the word the line toggles so stale bits never match
			rxDataPin <= (i < bits) ? rxWord[15 - i] : ~rxDataPin;
			#40;
			linkClk <= 1'b1;
			if (i > 0 && i <= 16)
				txSeen[16 - i] = txDataPin;
			#80;
			linkClk <= 1'b0;
			#40;
		end
		rxFrameSync <= 1'b0;
		txFrameSync <= 1'b0;
	endtask
endmodule

// File: verification/buffered_serial_port_tb.sv
/*
 Self-checking bench for the buffered serial port: AXI4-Lite master tasks
 and frame calls into the link model. Assumes a 125 MHz ref_clk.
*/
module buffered_serial_port_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import serial_port_pkg::*;

	logic ref_clk = 1'b0;
	logic reset_n = 1'b0;
	logic [7:0] s_axi_awaddr = 8'h00;
	logic [7:0] s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	logic s_axi_rvalid, linkClk, rxFrameSync, rxDataPin, txFrameSync;
	logic txDataPin, irq;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [31:0] s_axi_rdata, d;
	logic [15:0] tx;
	int errorCnt = 0;
	int compares = 0;

	initial forever #4 ref_clk = ~ref_clk;

	buffered_serial_port buffered_serial_port_i (.ref_clk(ref_clk),
		.reset_n(reset_n), .s_axi_awaddr(s_axi_awaddr),
		.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hf),
		.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
		.s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
		.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
		.s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
		.linkClk(linkClk), .rxFrameSync(rxFrameSync),
		.rxDataPin(rxDataPin), .txFrameSync(txFrameSync),
		.txDataPin(txDataPin), .irq(irq));

	serial_link_model serial_link_model_i (.linkClk(linkClk),
		.rxFrameSync(rxFrameSync), .rxDataPin(rxDataPin),
		.txFrameSync(txFrameSync), .txDataPin(txDataPin));

	task automatic check(input string name, input logic [31:0] seen,
		input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			errorCnt++;
			$display("Error %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic tallyAndFinish();
		$display("Checks %0d mismatches %0d", compares, errorCnt);
		if (errorCnt == 0 && compares > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	// Ready is looked at on the falling edge, where it is already settled
	task automatic wr(input logic [7:0] a, input logic [31:0] v,
		input logic [1:0] er);
		logic ga, gw, gb;
		logic [1:0] rs;
		@(posedge ref_clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		for (int i = 0; i < 50; i++) begin
			@(negedge ref_clk);
			ga = s_axi_awvalid && s_axi_awready;
			gw = s_axi_wvalid && s_axi_wready;
			gb = s_axi_bvalid;
			rs = s_axi_bresp;
			@(posedge ref_clk);
			if (ga) s_axi_awvalid <= 1'b0;
			if (gw) s_axi_wvalid <= 1'b0;
			if (gb) begin
				s_axi_bready <= 1'b0;
				check("bresp", 32'(rs), 32'(er));
				return;
			end
		end
		errorCnt++;
		tallyAndFinish();
	endtask

	task automatic rd(input logic [7:0] a, input logic [1:0] er,
		output logic [31:0] v);
		logic ga, gr;
		logic [1:0] rs;
		@(posedge ref_clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		for (int i = 0; i < 50; i++) begin
			@(negedge ref_clk);
			ga = s_axi_arvalid && s_axi_arready;
			gr = s_axi_rvalid;
			v = s_axi_rdata;
			rs = s_axi_rresp;
			@(posedge ref_clk);
			if (ga) s_axi_arvalid <= 1'b0;
			if (gr) begin
				s_axi_rready <= 1'b0;
				check("rresp", 32'(rs), 32'(er));
				return;
			end
		end
		errorCnt++;
		tallyAndFinish();
	endtask

	// Frame, then time for the three-flop sampling and stage moves
	task automatic fr(input logic [15:0] w, input int n, input logic r,
		input logic t);
		serial_link_model_i.frame(w, n, r, t, tx);
		repeat (12) @(posedge ref_clk);
	endtask

	task automatic st(input int b, input logic e);
		rd(OFS_STATUS, RESP_OKAY, d);
		check("status bit", 32'(d[b]), 32'(e));
	endtask

	task automatic chkIrq(input logic e);
		@(negedge ref_clk);
		check("irq", 32'(irq), 32'(e));
	endtask

	// Main sequence
	initial begin
		repeat (2) @(posedge ref_clk);
		reset_n <= 1'b1;
		rd(OFS_STATUS, RESP_OKAY, d);
		check("status", 32'(d[3:0]), 32'h2);
		rd(OFS_IRQ_MASK, RESP_OKAY, d);
		check("mask", d, 32'(IRQ_MASK_RESET));
		wr(OFS_TX_DATA, 32'h0000a5c3, RESP_OKAY);
		wr(OFS_TX_DATA, 32'h00003c5a, RESP_OKAY);
		rd(OFS_TX_DATA, RESP_OKAY, d);
		check("tx data", 32'(d[15:0]), 32'h3c5a);
		fr(16'h1234, 16, 1'b1, 1'b1);
		check("tx word", 32'(tx), 32'h3c5a);
		rd(OFS_RX_DATA, RESP_OKAY, d);
		check("rx word", 32'(d[15:0]), 32'h1234);
		st(ST_TXEMPTY, 1'b1);
		st(ST_RXFULL, 1'b0);
		// Three unread words with no new transmit word
		for (int k = 0; k < 3; k++) begin
			fr(16'h8001 >> k, 16, 1'b1, 1'b1);
			check("tx resend", 32'(tx), 32'h3c5a);
			st(ST_TXEMPTY, 1'b0);
		end
		st(ST_RXFULL, 1'b1);
		// Mask open so full or empty leaking into irq would show
		wr(OFS_IRQ_MASK, 32'h3, RESP_OKAY);
		chkIrq(1'b0);
		rd(OFS_RX_DATA, RESP_OKAY, d);
		check("rx kept", 32'(d[15:0]), 32'h8001);
		st(ST_RXFULL, 1'b0);
		wr(8'h14, 32'h1, RESP_SLVERR);
		rd(8'h14, RESP_SLVERR, d);
		check("unmapped", d, 32'h0);
		// Early receive sync, interrupt masked first
		wr(OFS_IRQ_MASK, 32'h0, RESP_OKAY);
		fr(16'hffff, 8, 1'b1, 1'b0);
		fr(16'h0f0f, 16, 1'b1, 1'b0);
		st(ST_RXSYNCERR, 1'b1);
		rd(OFS_RX_DATA, RESP_OKAY, d);
		check("rx held", 32'(d[15:0]), 32'h4000);
		rd(OFS_RX_DATA, RESP_OKAY, d);
		check("rx restart", 32'(d[15:0]), 32'h0f0f);
		rd(OFS_IRQ_STAT, RESP_OKAY, d);
		check("irq stat", 32'(d[1:0]), 32'h1);
		chkIrq(1'b0);
		wr(OFS_IRQ_MASK, 32'h3, RESP_OKAY);
		chkIrq(1'b1);
		wr(OFS_IRQ_STAT, 32'h1, RESP_OKAY);
		chkIrq(1'b0);
		// Early transmit sync
		wr(OFS_TX_DATA, 32'h00000ff0, RESP_OKAY);
		fr(16'h0000, 8, 1'b0, 1'b1);
		fr(16'h0000, 16, 1'b0, 1'b1);
		check("tx restart", 32'(tx), 32'h0ff0);
		st(ST_TXSYNCERR, 1'b1);
		rd(OFS_IRQ_STAT, RESP_OKAY, d);
		check("irq stat", 32'(d[1:0]), 32'h2);
		chkIrq(1'b1);
		tallyAndFinish();
	end
endmodule
